/* File: bst_exec.sv */
// execution unit for transfer, bit and shift/rotate operations
// assumes a decoder on clk_sys presents one op per cycle with op_valid
// and a register file that takes result back while result_we pulses
//
// Overview of operation
// - Port read loads the I/O value; port write sends the source out.
// - Push stores the source on the stack; pop loads the stack top.
// - I/O bit set forces the chosen I/O bit to one, bit clear to zero.
// - Logical left shift moves bits up and loads zero into bit 0.
// - Logical right shift moves bits down and loads zero into bit 7.
// - Rotate left puts old carry into bit 0 and old bit 7 into carry.
// - Rotate right puts old carry into bit 7 and old bit 0 into carry.
// - Arithmetic right shift moves bits down while bit 7 keeps its value.
// - Nibble swap exchanges the low and high four bits at once.
// - Status set forces the chosen flag to one, status clear to zero.
// - Bit store copies a source bit to the copy flag, bit load reverses.
// - Carry set forces carry to one, carry clear forces it to zero.
// - Negative set forces negative to one, negative clear to zero.
// - Shifts and rotates update Z, C, N, V and S; transfers and swap do not.
`timescale 1ns/1ps
`include "bst_consts.svh"
module bst_exec import bst_pkg::*; #(
	parameter int DATA_W = `BST_DATA_W
) (
	input wire logic clk_sys, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic op_valid, // one-cycle op strobe
	input wire bst_op_t op_code, // operation select
	input wire logic [DATA_W-1:0] dest_val, // destination register value
	input wire logic [DATA_W-1:0] source_reg, // source register value
	input wire logic [DATA_W-1:0] io_rd_data, // addressed I/O location
	input wire logic [DATA_W-1:0] stack_rd_data, // top of stack
	input wire logic [2:0] bit_sel, // bit or flag select
	output logic [DATA_W-1:0] result, // value for destination register
	output logic result_we, // result write pulse
	output logic [DATA_W-1:0] io_wr_data, // value for I/O location
	output logic io_we, // I/O write pulse
	output logic [DATA_W-1:0] stack_wr_data, // value pushed
	output logic stack_push, // push pulse
	output logic stack_pop, // pop pulse
	output logic [7:0] status_flags_reg // status flags
);
	// ***************************************
	// next-state computation
	// ***************************************
	logic [DATA_W-1:0] next_result;
	logic next_result_we;
	logic [DATA_W-1:0] next_io_wr_data;
	logic next_io_we;
	logic [DATA_W-1:0] next_stack_wr_data;
	logic next_stack_push;
	logic next_stack_pop;
	logic [7:0] next_flags;
	logic [DATA_W-1:0] bit_mask;
	logic [DATA_W-1:0] shift_res;
	logic shift_c;
	logic shift_op;
	logic carry_in;

	// ***************************************
	// one-hot bit select
	// ***************************************
	// a mask picks one bit; the other bits pass from io_rd_data into the write path unchanged
	genvar gi;
	generate
		for (gi = 0; gi < DATA_W; gi = gi + 1) begin : g_mask
			assign bit_mask[gi] = (bit_sel == 3'(gi));
		end
	endgenerate

	// ***************************************
	// shift and rotate unit
	// ***************************************
	// decoded from op_code alone; op_valid gates its use further down
	always_comb begin
		carry_in = status_flags_reg[`BST_FLAG_C];
		shift_res = dest_val;
		shift_c = 1'b0;
		shift_op = 1'b1;
		case (op_code)
			BST_OP_SHL: begin
				shift_res = {dest_val[DATA_W-2:0], 1'b0};
				shift_c = dest_val[DATA_W-1];
			end
			BST_OP_SHR: begin
				shift_res = {1'b0, dest_val[DATA_W-1:1]};
				shift_c = dest_val[0];
			end
			BST_OP_ROL: begin
				shift_res = {dest_val[DATA_W-2:0], carry_in};
				shift_c = dest_val[DATA_W-1];
			end
			BST_OP_ROR: begin
				shift_res = {carry_in, dest_val[DATA_W-1:1]};
				shift_c = dest_val[0];
			end
			BST_OP_ASR: begin
				shift_res = {dest_val[DATA_W-1], dest_val[DATA_W-1:1]};
				shift_c = dest_val[0];
			end
			default: shift_op = 1'b0;
		endcase
	end

	// ***************************************
	// op decode
	// ***************************************
	// defaults hold the data outputs and drop every pulse
	always_comb begin
		logic [DATA_W-1:0] r;
		r = dest_val;
		next_result = result;
		next_result_we = 1'b0;
		next_io_wr_data = io_wr_data;
		next_io_we = 1'b0;
		next_stack_wr_data = stack_wr_data;
		next_stack_push = 1'b0;
		next_stack_pop = 1'b0;
		next_flags = status_flags_reg;
		if (op_valid) begin
			case (op_code)
				BST_OP_PORT_READ: begin
					r = io_rd_data;
					next_result_we = 1'b1;
				end
				BST_OP_PORT_WRITE: begin
					next_io_wr_data = source_reg;
					next_io_we = 1'b1;
				end
				BST_OP_PUSH: begin
					next_stack_wr_data = source_reg;
					next_stack_push = 1'b1;
				end
				BST_OP_POP: begin
					r = stack_rd_data;
					next_stack_pop = 1'b1;
					next_result_we = 1'b1;
				end
				BST_OP_IO_BIT_SET: begin
					next_io_wr_data = io_rd_data | bit_mask;
					next_io_we = 1'b1;
				end
				BST_OP_IO_BIT_CLEAR: begin
					next_io_wr_data = io_rd_data & ~bit_mask;
					next_io_we = 1'b1;
				end
				BST_OP_SHL, BST_OP_SHR, BST_OP_ROL, BST_OP_ROR,
				BST_OP_ASR: begin
					r = shift_res;
					next_result_we = 1'b1;
				end
				BST_OP_SWAP: begin
					r = {dest_val[3:0], dest_val[7:4]};
					next_result_we = 1'b1;
				end
				BST_OP_STATUS_SET: begin
					next_flags[bit_sel] = 1'b1;
				end
				BST_OP_STATUS_CLEAR: begin
					next_flags[bit_sel] = 1'b0;
				end
				BST_OP_BIT_TO_FLAG: begin
					next_flags[`BST_FLAG_T] = source_reg[bit_sel];
				end
				BST_OP_FLAG_TO_BIT: begin
					r[bit_sel] = status_flags_reg[`BST_FLAG_T];
					next_result_we = 1'b1;
				end
				BST_OP_CARRY_SET: begin
					next_flags[`BST_FLAG_C] = 1'b1;
				end
				BST_OP_CARRY_CLEAR: begin
					next_flags[`BST_FLAG_C] = 1'b0;
				end
				BST_OP_NEG_SET: begin
					next_flags[`BST_FLAG_N] = 1'b1;
				end
				BST_OP_NEG_CLEAR: begin
					next_flags[`BST_FLAG_N] = 1'b0;
				end
				default: begin
				end
			endcase
			if (shift_op) begin
				// v = n xor c, s = n xor v as the core defines them
				next_flags[`BST_FLAG_C] = shift_c;
				next_flags[`BST_FLAG_Z] = (shift_res == '0);
				next_flags[`BST_FLAG_N] = shift_res[DATA_W-1];
				next_flags[`BST_FLAG_V] = shift_res[DATA_W-1] ^ shift_c;
				next_flags[`BST_FLAG_S] = shift_c;
			end
			if (next_result_we) begin
				next_result = r;
			end
		end
	end

	// ***************************************
	// registers
	// ***************************************
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			result <= '0;
			result_we <= 1'b0;
			io_wr_data <= '0;
			io_we <= 1'b0;
			stack_wr_data <= '0;
			stack_push <= 1'b0;
			stack_pop <= 1'b0;
			status_flags_reg <= `BST_FLAGS_RESET;
		end else begin
			result <= next_result;
			result_we <= next_result_we;
			io_wr_data <= next_io_wr_data;
			io_we <= next_io_we;
			stack_wr_data <= next_stack_wr_data;
			stack_push <= next_stack_push;
			stack_pop <= next_stack_pop;
			status_flags_reg <= next_flags;
		end
	end
endmodule

/* File: bst_consts.svh */
// timing-free constants for the bit/shift/transfer execution unit
// assumes inclusion by bare name from the package or the unit
`ifndef BST_CONSTS_SVH
`define BST_CONSTS_SVH
`define BST_DATA_W 8
`define BST_FLAG_C 0
`define BST_FLAG_Z 1
`define BST_FLAG_N 2
`define BST_FLAG_V 3
`define BST_FLAG_S 4
`define BST_FLAG_H 5
`define BST_FLAG_T 6
`define BST_FLAG_I 7
`define BST_FLAGS_RESET 8'h00
`define BST_OP_W 5
`endif

/* File: bst_pkg.sv */
// types shared by the bit/shift/transfer execution unit
// assumes bst_consts.svh is on the include path
package bst_pkg;
`include "bst_consts.svh"
	typedef enum logic [`BST_OP_W-1:0] {
		BST_OP_NONE = 5'h00,
		BST_OP_PORT_READ = 5'h01,
		BST_OP_PORT_WRITE = 5'h02,
		BST_OP_PUSH = 5'h03,
		BST_OP_POP = 5'h04,
		BST_OP_IO_BIT_SET = 5'h05,
		BST_OP_IO_BIT_CLEAR = 5'h06,
		BST_OP_SHL = 5'h07,
		BST_OP_SHR = 5'h08,
		BST_OP_ROL = 5'h09,
		BST_OP_ROR = 5'h0A,
		BST_OP_ASR = 5'h0B,
		BST_OP_SWAP = 5'h0C,
		BST_OP_STATUS_SET = 5'h0D,
		BST_OP_STATUS_CLEAR = 5'h0E,
		BST_OP_BIT_TO_FLAG = 5'h0F,
		BST_OP_FLAG_TO_BIT = 5'h10,
		BST_OP_CARRY_SET = 5'h11,
		BST_OP_CARRY_CLEAR = 5'h12,
		BST_OP_NEG_SET = 5'h13,
		BST_OP_NEG_CLEAR = 5'h14
	} bst_op_t;
endpackage

/* File: bst_exec_chk.sv */
// checker for the bit/shift/transfer unit, bound onto bst_exec
// assumes one clk_sys domain and ops that answer one cycle later
`timescale 1ns/1ps
module bst_exec_chk import bst_pkg::*; (
	input wire logic clk_sys, // core clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic op_valid, // op strobe
	input wire bst_op_t op_code, // operation
	input wire logic [7:0] dest_val, // destination operand
	input wire logic [7:0] source_reg, // source operand
	input wire logic [7:0] io_rd_data, // I/O read value
	input wire logic [7:0] stack_rd_data, // top of stack
	input wire logic [2:0] bit_sel, // bit select
	input wire logic [7:0] result, // result out
	input wire logic result_we, // result pulse
	input wire logic [7:0] io_wr_data, // I/O write value
	input wire logic io_we, // I/O write pulse
	input wire logic [7:0] stack_wr_data, // pushed value
	input wire logic stack_push, // push pulse
	input wire logic stack_pop, // pop pulse
	input wire logic [7:0] status_flags_reg // flags
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// ****************
	// op taken
	// ****************
	sequence s_take(bst_op_t op);
		op_valid && op_code == op;
	endsequence
	chk_pop_loads_result: assert property (s_take(BST_OP_POP) |=>
		result_we && stack_pop && result == $past(stack_rd_data))
		else $error("pop result wrong");
	chk_push_stores_source: assert property (s_take(BST_OP_PUSH) |=>
		stack_push && stack_wr_data == $past(source_reg))
		else $error("push data wrong");
	chk_port_write_data: assert property (s_take(BST_OP_PORT_WRITE) |=>
		io_we && io_wr_data == $past(source_reg))
		else $error("port write wrong");
	chk_io_bit_set: assert property (s_take(BST_OP_IO_BIT_SET) |=>
		io_wr_data == ($past(io_rd_data) | (8'h01 << $past(bit_sel))))
		else $error("io bit set wrong");
	chk_shl_result_carry: assert property (s_take(BST_OP_SHL) |=>
		result == {$past(dest_val[6:0]), 1'b0}
		&& status_flags_reg[0] == $past(dest_val[7]))
		else $error("left shift wrong");
	chk_asr_keeps_sign: assert property (s_take(BST_OP_ASR) |=>
		result == {$past(dest_val[7]), $past(dest_val[7:1])})
		else $error("arith shift wrong");
	chk_swap_no_flags: assert property (s_take(BST_OP_SWAP) |=>
		$stable(status_flags_reg)
		&& result == {$past(dest_val[3:0]), $past(dest_val[7:4])})
		else $error("swap wrong");
	chk_carry_set_one: assert property (s_take(BST_OP_CARRY_SET) |=>
		status_flags_reg[0]) else $error("carry set wrong");
	chk_ror_carry_in: assert property (s_take(BST_OP_ROR) |=>
		result == {$past(status_flags_reg[0]), $past(dest_val[7:1])}
		&& status_flags_reg[0] == $past(dest_val[0]))
		else $error("right rotate wrong");
endmodule
bind bst_exec bst_exec_chk bst_exec_chk_i(.clk_sys(clk_sys), .rst_n(rst_n),
	.op_valid(op_valid), .op_code(op_code), .dest_val(dest_val),
	.source_reg(source_reg), .io_rd_data(io_rd_data), .result(result),
	.stack_rd_data(stack_rd_data), .io_wr_data(io_wr_data), .io_we(io_we),
	.bit_sel(bit_sel), .result_we(result_we), .stack_push(stack_push),
	.stack_pop(stack_pop), .stack_wr_data(stack_wr_data),
	.status_flags_reg(status_flags_reg));

/* File: bst_exec_tb_top.sv */
// random op stream against a behavioural model of the unit
// assumes latency one: results seen one cycle after the op is driven
`timescale 1ns/1ps
module bst_exec_tb_top import bst_pkg::*; ;
	logic clk_sys, rst_n, op_valid, result_we, io_we, stack_push, stack_pop;
	bst_op_t op_code;
	logic [7:0] dest_val, source_reg, io_rd_data, stack_rd_data, result;
	logic [7:0] io_wr_data, stack_wr_data, status_flags_reg, r, m;
	logic [7:0] e_res = 0, e_io = 0, e_stk = 0, e_fl = 0;
	logic [3:0] e_pul = 0;
	logic [2:0] bit_sel;
	logic c, sh;
	int n_fail = 0, checks_done = 0, cyc = 0;
	bst_exec bst_exec_i(.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
		.op_code(op_code), .dest_val(dest_val), .source_reg(source_reg),
		.io_rd_data(io_rd_data), .stack_rd_data(stack_rd_data),
		.bit_sel(bit_sel), .result(result), .result_we(result_we),
		.io_wr_data(io_wr_data), .io_we(io_we), .stack_wr_data(stack_wr_data),
		.stack_push(stack_push), .stack_pop(stack_pop),
		.status_flags_reg(status_flags_reg));
	always #5 clk_sys = ~clk_sys;
	task chk(input logic [7:0] e, g);
		checks_done++;
		if (e !== g) begin
			n_fail++;
			$display("wrong value at %0t: exp %h got %h", $time, e, g);
		end
	endtask
	task wrap_up;
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// hang guard well above the 3000 op cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			wrap_up;
		end
	end
	// ****************
	// compare then drive the next op
	// ****************
	// run from the seeded initial thread so the seed reaches the stimulus
	task step;
		chk(e_res, result);
		chk(e_io, io_wr_data);
		chk(e_stk, stack_wr_data);
		chk(e_fl, status_flags_reg);
		chk({4'h0, e_pul},
			{4'h0, result_we, io_we, stack_push, stack_pop});
		// codes past 0x14 included so refusal is exercised
		op_valid = ($urandom % 8) != 0;
		op_code = bst_op_t'(5'($urandom % 22));
		dest_val = 8'($urandom);
		source_reg = 8'($urandom);
		io_rd_data = 8'($urandom);
		stack_rd_data = 8'($urandom);
		bit_sel = 3'($urandom);
		m = 8'h01 << bit_sel;
		e_pul = 4'h0;
		sh = 0;
		if (op_valid) case (op_code)
			BST_OP_PORT_READ: begin
				e_res = io_rd_data;
				e_pul = 4'h8;
			end
			BST_OP_PORT_WRITE: begin
				e_io = source_reg;
				e_pul = 4'h4;
			end
			BST_OP_PUSH: begin
				e_stk = source_reg;
				e_pul = 4'h2;
			end
			BST_OP_POP: begin
				e_res = stack_rd_data;
				e_pul = 4'h9;
			end
			BST_OP_IO_BIT_SET: begin
				e_io = io_rd_data | m;
				e_pul = 4'h4;
			end
			BST_OP_IO_BIT_CLEAR: begin
				e_io = io_rd_data & ~m;
				e_pul = 4'h4;
			end
			BST_OP_SHL: begin
				{c, r} = {dest_val, 1'b0};
				sh = 1;
			end
			BST_OP_SHR: begin
				{r, c} = {1'b0, dest_val};
				sh = 1;
			end
			BST_OP_ROL: begin
				{c, r} = {dest_val, e_fl[0]};
				sh = 1;
			end
			BST_OP_ROR: begin
				{r, c} = {e_fl[0], dest_val};
				sh = 1;
			end
			BST_OP_ASR: begin
				{r, c} = {dest_val[7], dest_val};
				sh = 1;
			end
			BST_OP_SWAP: begin
				e_res = {dest_val[3:0], dest_val[7:4]};
				e_pul = 4'h8;
			end
			BST_OP_STATUS_SET: e_fl = e_fl | m;
			BST_OP_STATUS_CLEAR: e_fl = e_fl & ~m;
			BST_OP_BIT_TO_FLAG: e_fl[6] = source_reg[bit_sel];
			BST_OP_FLAG_TO_BIT: begin
				e_res = dest_val;
				e_res[bit_sel] = e_fl[6];
				e_pul = 4'h8;
			end
			BST_OP_CARRY_SET: e_fl[0] = 1'b1;
			BST_OP_CARRY_CLEAR: e_fl[0] = 1'b0;
			BST_OP_NEG_SET: e_fl[2] = 1'b1;
			BST_OP_NEG_CLEAR: e_fl[2] = 1'b0;
			default: ;
		endcase
		if (sh) begin
			e_res = r;
			e_pul = 4'h8;
			e_fl[4:0] = {c, r[7] ^ c, r[7], r == 8'h00, c};
		end
	endtask
	initial begin
		{clk_sys, rst_n, op_valid, bit_sel} = '0;
		op_code = BST_OP_NONE;
		{dest_val, source_reg, io_rd_data, stack_rd_data} = '0;
		void'($urandom(32'h24080C0E));
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1;
		repeat (3000) begin
			@(negedge clk_sys);
			step();
		end
		wrap_up;
	end
endmodule
